// File: pkg/srpu_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SRPU_MAP_SVH
`define SRPU_MAP_SVH
`define SRPU_OFF_RESET_CONTROL 8'h10
`define SRPU_OFF_UNLOCK_KEY 8'h14
`define SRPU_OFF_PIN_RECORD 8'h18
`define SRPU_OFF_IRQ_STATUS 8'h1c
`define SRPU_OFF_IRQ_MASK 8'h20
`define SRPU_OFF_CLOCK_CONFIG 8'h0c
`define SRPU_BIT_DIGITAL 0
`define SRPU_BIT_PORT_A 1
`define SRPU_BIT_PORT_B 2
`define SRPU_BIT_SLAVE_CORE 6
`define SRPU_BIT_REL_A 8
`define SRPU_BIT_REL_B 9
`define SRPU_BIT_SEEN_CLEAR 0
`define SRPU_BIT_SEEN 1
`define SRPU_RST_RESET_CONTROL 32'h0000_0000
`define SRPU_RST_PIN_RECORD 32'h0000_0002
`define SRPU_RST_CLOCK_CONFIG 32'h0528_0400
`define SRPU_CLK_CFG_MASK 32'h0f3f_0700
`define SRPU_UNLOCK_VALUE 32'h78b4_65a1
`define SRPU_HOLD_NS 1000
`define SRPU_CLK_NS 100
`define SRPU_HOLD_CYCLES ((`SRPU_HOLD_NS + `SRPU_CLK_NS - 1) / `SRPU_CLK_NS)
`endif

// File: pkg/srpu_pkg.sv
// Types shared by the soft reset unit
`default_nettype none
package srpu_pkg;
  // One captured AHB-Lite address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [2:0] size;
  } srpu_req_type;
  // Reset pulse states
  typedef enum logic [1:0] {SRPU_IDLE, SRPU_HOLD, SRPU_DONE} srpu_state_type;
endpackage : srpu_pkg
`default_nettype wire

// File: core/srpu_pulse.sv
// Self-timed reset pulse generator for one reset target
`default_nettype none
`include "srpu_map.svh"
module srpu_pulse #(
  parameter int HOLD = `SRPU_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic rst_active,
  output logic done
);
  import srpu_pkg::*;
  srpu_state_type state_q;
  logic [15:0] cnt_q;
  // Count out the hold time, then report the release for one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SRPU_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        SRPU_IDLE: if (start) begin
          state_q <= SRPU_HOLD;
          cnt_q <= 16'(HOLD - 1);
        end
        SRPU_HOLD: if (cnt_q == 16'h0000) state_q <= SRPU_DONE; else cnt_q <= cnt_q - 16'h0001;
        SRPU_DONE: state_q <= SRPU_IDLE;
      endcase
    end
  end
  assign rst_active = (state_q == SRPU_HOLD);
  assign done = (state_q == SRPU_DONE);
endmodule : srpu_pulse
`default_nettype wire

// File: core/srpu_sync.sv
// Three-stage synchroniser with agreement filter
`default_nettype none
module srpu_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  // Only the second stage reads the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) out_q <= s3_q;
    end
  end
  assign dout = out_q;
endmodule : srpu_sync
`default_nettype wire

// File: core/srpu_top.sv
// Soft reset control, PLL setup unlock and pin reset record over AHB-Lite
`default_nettype none
`include "srpu_map.svh"
// Overview of operation
// - Writing 1 to bit 6 resets the slave core; bit clears on release.
// - Writes to slave core or digital reset bits are ignored while set.
// - Writing 1 to bit 2 resets port B transceiver; clears on release.
// - Writing 1 to bit 1 resets port A transceiver; clears on release.
// - Writes to a set transceiver reset bit are discarded until cleared.
// - Bit 0 resets whole chip except PLL and transceivers; clears on release.
// - Bit 9 low holds port B transceiver in reset, high releases it.
// - Bit 8 low holds port A transceiver in reset, high releases it.
// - Release bits act only while hold-select mode input is 1.
// - Writing 0x78b465a1 to offset 0x14 sets the unlock bit.
// - PLL fields of clock config are accessible only while unlocked.
// - Unlock register takes only full word transfers.
// - Reset control resets to zero; pin record resets to 0x2.
// - Pin reset seen flag sets on pin reset, clears on clear bit.
module srpu_top #(
  parameter int HOLD = `SRPU_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pin_reset_n,
  input wire logic phy_hold_mode,
  output logic slave_core_rst,
  output logic port_a_phy_rst,
  output logic port_b_phy_rst,
  output logic digital_rst,
  output logic [31:0] clock_config,
  output logic irq
);
  import srpu_pkg::*;

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  srpu_req_type req_q;
  logic [31:0] rdata_q;
  wire addr_phase = hsel && htrans[1] && hready;
  wire wr_en = req_q.valid && req_q.write;
  wire rd_phase = addr_phase && !hwrite;
  wire [7:0] rd_addr = haddr[7:0];
  wire word_size = (req_q.size == 3'h2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q <= '{valid: addr_phase, write: hwrite, addr: haddr[7:0], size: hsize};
    end
  end

  // ----------------------------------------
  // Register write decode and status read strobe
  // ----------------------------------------
  wire wr_ctl = wr_en && req_q.addr == `SRPU_OFF_RESET_CONTROL;
  wire wr_key = wr_en && word_size && req_q.addr == `SRPU_OFF_UNLOCK_KEY;
  wire wr_pin = wr_en && req_q.addr == `SRPU_OFF_PIN_RECORD;
  wire wr_mask = wr_en && req_q.addr == `SRPU_OFF_IRQ_MASK;
  wire wr_clk = wr_en && req_q.addr == `SRPU_OFF_CLOCK_CONFIG;
  wire rd_status = rd_phase && rd_addr == `SRPU_OFF_IRQ_STATUS;

  // ----------------------------------------
  // Reset control register and pulse engines
  // ----------------------------------------
  logic core_q, pa_q, pb_q, dig_q, rel_a_q, rel_b_q;
  logic [3:0] start;
  logic [3:0] active;
  logic [3:0] done;
  // Order: digital, port A, port B, slave core
  assign start[0] = wr_ctl && !dig_q && hwdata[`SRPU_BIT_DIGITAL];
  assign start[1] = wr_ctl && !pa_q && hwdata[`SRPU_BIT_PORT_A];
  assign start[2] = wr_ctl && !pb_q && hwdata[`SRPU_BIT_PORT_B];
  assign start[3] = wr_ctl && !core_q && hwdata[`SRPU_BIT_SLAVE_CORE];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pulse
      srpu_pulse #(.HOLD(HOLD)) u_pulse (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start[gi]),
        .rst_active(active[gi]),
        .done(done[gi])
      );
    end
  endgenerate

  // Self-clearing and release bits; only the bus reset reaches them, never the digital one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_q <= 1'b0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      core_q <= 1'b0;
      rel_a_q <= 1'b0;
      rel_b_q <= 1'b0;
    end else begin
      if (start[0]) dig_q <= 1'b1; else if (done[0]) dig_q <= 1'b0;
      if (start[1]) pa_q <= 1'b1; else if (done[1]) pa_q <= 1'b0;
      if (start[2]) pb_q <= 1'b1; else if (done[2]) pb_q <= 1'b0;
      if (start[3]) core_q <= 1'b1; else if (done[3]) core_q <= 1'b0;
      if (wr_ctl) begin
        rel_a_q <= hwdata[`SRPU_BIT_REL_A];
        rel_b_q <= hwdata[`SRPU_BIT_REL_B];
      end
    end
  end

  // Transceiver hold only counts in hold-select mode
  wire mode_sync;
  srpu_sync u_mode_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(phy_hold_mode),
    .dout(mode_sync)
  );
  wire hold_a = mode_sync && !rel_a_q;
  wire hold_b = mode_sync && !rel_b_q;

  // Registered reset outputs; digital reset spares PLL and transceivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      digital_rst <= 1'b0;
      port_a_phy_rst <= 1'b0;
      port_b_phy_rst <= 1'b0;
      slave_core_rst <= 1'b0;
    end else begin
      digital_rst <= active[0];
      port_a_phy_rst <= active[1] || hold_a;
      port_b_phy_rst <= active[2] || hold_b;
      slave_core_rst <= active[3] || active[0];
    end
  end

  // ----------------------------------------
  // PLL unlock key and clock configuration
  // ----------------------------------------
  logic key_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_q <= 1'b0;
      clock_config <= `SRPU_RST_CLOCK_CONFIG;
    end else begin
      if (wr_key) key_q <= (hwdata == `SRPU_UNLOCK_VALUE);
      if (wr_clk && key_q) clock_config <= hwdata & `SRPU_CLK_CFG_MASK;
    end
  end

  // ----------------------------------------
  // Pin reset record
  // ----------------------------------------
  wire pin_low;
  srpu_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(!pin_reset_n),
    .dout(pin_low)
  );
  localparam logic [31:0] PIN_RECORD_RST = `SRPU_RST_PIN_RECORD;
  logic seen_q;
  logic pin_low_q;
  wire pin_event = pin_low && !pin_low_q;
  wire seen_clr = wr_pin && hwdata[`SRPU_BIT_SEEN_CLEAR];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= PIN_RECORD_RST[`SRPU_BIT_SEEN];
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= pin_low;
      if (pin_event) seen_q <= 1'b1; else if (seen_clr) seen_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  wire [3:0] irq_ev = {done[3], done[2], done[1], pin_event};
  // Set wins over the clear-on-read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (rd_status ? 4'h0 : irq_stat_q) | irq_ev;
      if (wr_mask) irq_mask_q <= hwdata[3:0];
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Read data, zero for unmapped offsets
  // ----------------------------------------
  wire [31:0] ctl_rd = {22'h0, rel_b_q, rel_a_q, 1'b0, core_q, 3'h0, pb_q, pa_q, dig_q};
  wire [31:0] clk_rd = key_q ? clock_config : (clock_config & ~`SRPU_CLK_CFG_MASK);
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_addr)
      `SRPU_OFF_RESET_CONTROL: rd_mux = ctl_rd;
      `SRPU_OFF_UNLOCK_KEY: rd_mux = {31'h0, key_q};
      `SRPU_OFF_PIN_RECORD: rd_mux = {30'h0, seen_q, 1'b0};
      `SRPU_OFF_IRQ_STATUS: rd_mux = {28'h0, irq_stat_q};
      `SRPU_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
      `SRPU_OFF_CLOCK_CONFIG: rd_mux = clk_rd;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdata_q <= 32'h0000_0000;
    else if (rd_phase) rdata_q <= rd_mux;
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  core_bit_clear_a: assert property (start[3] |-> ##(HOLD + 1) core_q ##1 !core_q) else $error("core bit stuck");
  ignore_busy_a: assert property (dig_q && !done[0] |=> dig_q) else $error("digital bit dropped");
  pb_reset_out_a: assert property (start[2] |-> ##2 port_b_phy_rst) else $error("port b no reset");
  pa_reset_out_a: assert property (start[1] |-> ##2 port_a_phy_rst) else $error("port a no reset");
  busy_no_start_a: assert property (pa_q |-> !start[1]) else $error("restart while busy");
  dig_spare_a: assert property (start[0] && !start[1] && !pa_q |=> (!hold_a |=> !port_a_phy_rst))
    else $error("phy hit");
  release_b_a: assert property (!mode_sync && !active[2] |=> !port_b_phy_rst) else $error("release outside mode");
  key_set_a: assert property (wr_key && hwdata == `SRPU_UNLOCK_VALUE |=> key_q) else $error("key not set");
  clk_lock_a: assert property (!key_q |=> $stable(clock_config)) else $error("locked write");
  seen_clear_a: assert property (seen_clr && !pin_event |=> !seen_q) else $error("seen not cleared");
endmodule : srpu_top
`default_nettype wire

// File: testbench/soft_reset_and_pll_unlock_tb_top.sv
// Self-checking bench for the soft reset and PLL unlock unit
`default_nettype none
module soft_reset_and_pll_unlock_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam int HOLD = 6;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [2:0] sz; logic [31:0] e;} srpu_row_type;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic pin_reset_n = 1;
  logic phy_hold_mode = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, clock_config, r;
  logic hready, hreadyout, hresp, slave_core_rst, port_a_phy_rst, port_b_phy_rst, digital_rst, irq;
  logic [3:0] rst_vec;
  int n_errors = 0;
  int checks = 0;
  int run = 0;
  int len = 0;
  int sel = 0;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  assign rst_vec = {slave_core_rst, port_b_phy_rst, port_a_phy_rst, digital_rst};
  srpu_top #(.HOLD(HOLD)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_reset_n(pin_reset_n), .phy_hold_mode(phy_hold_mode), .slave_core_rst(slave_core_rst),
    .port_a_phy_rst(port_a_phy_rst), .port_b_phy_rst(port_b_phy_rst), .digital_rst(digital_rst),
    .clock_config(clock_config), .irq(irq));
  // Clock, 100 ns period
  always #50 hclk = ~hclk;
  // Length of the last pulse on the watched reset output
  always @(posedge hclk) begin
    if (rst_vec[sel] === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      len <= run;
      run <= 0;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Single AHB-Lite transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  localparam srpu_row_type ROWS [7] = '{
    '{8'h20, 32'h0000_000f, 3'h2, 32'h0000_000f},
    '{8'h14, 32'h78b4_65a1, 3'h2, 32'h0000_0001},
    '{8'h0c, 32'h0a15_0300, 3'h2, 32'h0a15_0300},
    '{8'h14, 32'h0000_0000, 3'h1, 32'h0000_0001},
    '{8'h14, 32'h78b4_65a0, 3'h2, 32'h0000_0000},
    '{8'h0c, 32'h0f3f_0700, 3'h2, 32'h0a15_0300},
    '{8'h40, 32'hffff_ffff, 3'h2, 32'h0000_0000}};
  localparam int BITS [4] = '{1, 2, 6, 0};
  localparam int IDX [4] = '{1, 2, 3, 0};
  localparam logic [31:0] STAT [3] = '{32'h2, 32'h4, 32'h8};
  // Main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].sz);
      if (ROWS[i].a == 8'h0c) begin
        // Write lands at the closing edge; look once it has settled
        @(negedge hclk);
        chk(clock_config, ROWS[i].e, "clock config");
      end else begin
        bus(1'b0, ROWS[i].a, 0, 3'h2);
        chk(r, ROWS[i].e, "row readback");
      end
    end
    bus(1'b0, 8'h0c, 0, 3'h2);
    chk(r, 32'h0, "config hidden");
    chk({hreadyout, hresp}, 2'b10, "bus response");
    $display("register rows done");
    bus(1'b0, 8'h1c, 0, 3'h2);
    // Each soft reset: set, rewrite while set, pulse length, self clear
    for (int k = 0; k < 4; k++) begin
      sel = IDX[k];
      bus(1'b1, 8'h10, 32'h1 << BITS[k], 3'h2);
      bus(1'b1, 8'h10, 32'h0, 3'h2);
      bus(1'b0, 8'h10, 0, 3'h2);
      chk(r, 32'h1 << BITS[k], "reset bit held");
      repeat (HOLD + 4) @(posedge hclk);
      chk(len, HOLD, "pulse length");
      bus(1'b0, 8'h10, 0, 3'h2);
      chk(r, 32'h0, "self clear");
      if (k < 3) begin
        chk(irq, 1'b1, "irq raised");
        bus(1'b0, 8'h1c, 0, 3'h2);
        chk(r, STAT[k], "status");
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0, "irq cleared");
      end
    end
    // Unit keeps its own state across the whole-chip reset
    bus(1'b0, 8'h20, 0, 3'h2);
    chk(r, 32'hf, "mask kept");
    chk(clock_config, 32'h0a15_0300, "config kept");
    bus(1'b0, 8'h1c, 0, 3'h2);
    $display("soft reset tests done");
    // Release bits, honoured only in hold mode
    phy_hold_mode <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({port_b_phy_rst, port_a_phy_rst}, 2'b11, "both held");
    bus(1'b1, 8'h10, 32'h100, 3'h2);
    repeat (3) @(posedge hclk);
    chk({port_b_phy_rst, port_a_phy_rst}, 2'b10, "a released");
    bus(1'b1, 8'h10, 32'h300, 3'h2);
    repeat (3) @(posedge hclk);
    chk({port_b_phy_rst, port_a_phy_rst}, 2'b00, "b released");
    bus(1'b1, 8'h10, 32'h0, 3'h2);
    phy_hold_mode <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({port_b_phy_rst, port_a_phy_rst}, 2'b00, "mode off");
    $display("release tests done");
    // Pin reset record: clear, then a new pin pulse sets it
    bus(1'b0, 8'h18, 0, 3'h2);
    chk(r, 32'h2, "seen after reset");
    bus(1'b1, 8'h18, 32'h1, 3'h2);
    bus(1'b0, 8'h18, 0, 3'h2);
    chk(r, 32'h0, "seen cleared");
    pin_reset_n <= 1'b0;
    repeat (6) @(posedge hclk);
    pin_reset_n <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b0, 8'h18, 0, 3'h2);
    chk(r, 32'h2, "seen set");
    bus(1'b0, 8'h1c, 0, 3'h2);
    chk(r, 32'h1, "pin event");
    $display("pin record tests done");
    // Second reset in mid-run, then reset values
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h10, 0, 3'h2);
    chk(r, 32'h0, "control reset");
    bus(1'b0, 8'h14, 0, 3'h2);
    chk(r, 32'h0, "key reset");
    bus(1'b0, 8'h18, 0, 3'h2);
    chk(r, 32'h2, "record reset");
    chk(clock_config, 32'h0528_0400, "config reset");
    chk(irq, 1'b0, "irq reset");
    $display("reset tests done");
    complete_run();
  end
  // Watchdog, well beyond the expected run of a few hundred cycles
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    complete_run();
  end
endmodule : soft_reset_and_pll_unlock_tb_top
`default_nettype wire
